// file: shared/panel_seq_regs.svh
/*
  Named constants for the panel power sequencer and LVDS lane receiver.
  Assumes it is included by bare name wherever a count or position is used.
*/
`ifndef PANEL_SEQ_REGS_SVH
`define PANEL_SEQ_REGS_SVH

// ----------------------------------------------------------------
// Sequencing counts (frame sync falling edges)
// ----------------------------------------------------------------
// Falls seen before the one that starts the display (ninth fall)
`define PS_START_LAST 4'h8
// Frame periods run by the power-off sequence
`define PS_OFF_PERIODS 4'h7
// Increment step of the fall counter
`define PS_CNT_STEP 4'h1

// ----------------------------------------------------------------
// Lane layout
// ----------------------------------------------------------------
// Slot index that carries each bit, listed for bit6 down to bit0
`define LANE_SLOT_OF_BIT {3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h1}
// Lane carrying red high bits and green bit 2
`define LANE_IDX_A 2'h0
// Lane carrying green high bits and blue bits 3:2
`define LANE_IDX_B 2'h1
// Lane carrying blue high bits and the timing flags
`define LANE_IDX_C 2'h2
// Lane carrying the low two bits of each colour
`define LANE_IDX_D 2'h3
// Idle level of the link clock, loaded into its edge finder at reset
`define LINK_CLK_IDLE 1'h1

// ----------------------------------------------------------------
// Data path
// ----------------------------------------------------------------
// Colour value shown while blanked
`define PIX_BLACK 8'h00
// Default depth of the pixel FIFO
`define PIX_FIFO_DEPTH 32'h0000_0020

`endif

// file: shared/panel_seq_pkg.sv
/*
  Types shared by the panel power sequencer, the host link model and the bench.
  Assumes nothing beyond a SystemVerilog compiler; holds no numbers of timing.
*/
`default_nettype none

package panel_seq_pkg;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_WAIT   = 2'b00,  // Powered, blanked, counting falls to start
    ST_ON     = 2'b01,  // Image shown
    ST_OFFSEQ = 2'b10,  // Power-off sequence running
    ST_OFF    = 2'b11   // Sequence done, blanked until reset
  } pwr_state_e;

  // ----------------------------------------------------------------
  // Decoded lane words (bit6 on the left)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       green_b2;   // Bit 6
    logic [5:0] red_hi;     // Red bits 7:2
  } lane_a_s;

  typedef struct packed {
    logic [1:0] blue_mid;   // Blue bits 3:2
    logic [4:0] green_hi;   // Green bits 7:3
  } lane_b_s;

  typedef struct packed {
    logic       pixel_valid_window;
    logic       frame_sync_pulse;
    logic       line_sync_pulse;
    logic [3:0] blue_hi;    // Blue bits 7:4
  } lane_c_s;

  typedef struct packed {
    logic       spare;
    logic [1:0] blue_lo;
    logic [1:0] green_lo;
    logic [1:0] red_lo;
  } lane_d_s;

  // ----------------------------------------------------------------
  // Pixel word handed downstream
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       line_sync_pulse;
    logic       frame_sync_pulse;
    logic       pixel_valid_window;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_s;

  // ----------------------------------------------------------------
  // Whole state of the sequencer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]      clk_sync;   // Link clock synchroniser
    logic [1:0]      shut_sync;  // Shutdown request synchroniser
    logic [3:0][6:0] lane_s1;    // Lane first stage
    logic [3:0][6:0] lane_s2;    // Lane second stage
    logic            clk_prev;   // Link clock edge finder
    logic            shut_prev;  // Shutdown edge finder
    logic            vs_prev;    // Last frame sync level
    pwr_state_e      st;         // Power state
    logic [3:0]      fall_cnt;   // Frame sync falls counted
    logic            disp_on;    // Image shown
    logic            off_busy;   // Off sequence running
    logic            panel_off;  // Off sequence complete
    logic            overrun;    // Sticky: word lost on full FIFO
  } seq_state_s;

endpackage

`default_nettype wire

// file: hdl/pixel_fifo.sv
/*
  Pixel FIFO with registered output stage, flip-flop storage.
  Assumes DEPTH is a power of two and both sides on one clock.
*/
`timescale 1ns/1ns
`default_nettype none

module pixel_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_CNT = CW'(1);
  localparam logic [PW-1:0] ONE_PTR = PW'(1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage
    logic [PW-1:0] wr_ptr;             // Next write slot
    logic [PW-1:0] rd_ptr;             // Next read slot
    logic [CW-1:0] count;              // Words held in storage
    logic out_valid;                   // Output stage holds a word
    logic [WIDTH-1:0] out_data;        // Output stage word
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic push;
  logic pop;

  // Ready is honest: low exactly when storage is full
  assign in_ready_o = (q.count != FULL_CNT);
  assign push = in_valid_i && in_ready_o;
  // Refill the output stage when it is empty or being taken
  assign pop = (q.count != '0) && (!q.out_valid || out_ready_i);
  assign out_valid_o = q.out_valid;
  assign out_data_o = q.out_data;

  // Next state
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr_ptr] = in_data_i;
      d.wr_ptr = q.wr_ptr + ONE_PTR;
    end
    if (pop)
    begin
      d.out_data = q.mem[q.rd_ptr];
      d.out_valid = 1'b1;
      d.rd_ptr = q.rd_ptr + ONE_PTR;
    end
    else if (out_ready_i)
    begin
      d.out_valid = 1'b0;
    end
    if (push && !pop)
    begin
      d.count = q.count + ONE_CNT;
    end
    else if (pop && !push)
    begin
      d.count = q.count - ONE_CNT;
    end
  end

  // Register
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_fifo_count;
    (push && !pop) |=> (q.count == $past(q.count) + ONE_CNT);
  endproperty
  a_fifo_count: assert property (p_fifo_count) else $error("FIFO count did not grow on push");

  property p_fifo_stall;
    (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o));
  endproperty
  a_fifo_stall: assert property (p_fifo_stall) else $error("FIFO output moved while stalled");

endmodule

`default_nettype wire

// file: hdl/panel_power_sequence_lvds_rx.sv
/*
  Panel power sequencer with LVDS lane word decoder and pixel FIFO.
  Assumes lanes arrive as seven captured slot bits per lane, stable around
  the link clock rising edge; link clock and shutdown come from outside.
*/
// Functional notes
// - Image starts at ninth frame sync fall
// - Shutdown rising edge starts power-off sequence
// - Off sequence lasts seven frame periods
// - Lane slots carry bit1,0,6,5,4,3,2 in order
// - Single shutdown line governs power; high means off
`timescale 1ns/1ns
`default_nettype none

`include "panel_seq_regs.svh"

module panel_power_sequence_lvds_rx #(
  parameter int FIFO_DEPTH = `PIX_FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic [3:0][6:0] lane_slots_i,
  input wire logic shutdown_req_i,
  input wire logic px_ready_i,
  output logic px_valid_o,
  output panel_seq_pkg::pixel_s px_data_o,
  output logic display_on_o,
  output logic power_off_busy_o,
  output logic panel_off_o,
  output logic rx_overrun_o
);

  // ----------------------------------------------------------------
  // Constants and state
  // ----------------------------------------------------------------
  // Slot that carries each bit within a lane word
  localparam logic [6:0][2:0] SLOT_OF_BIT = `LANE_SLOT_OF_BIT;

  panel_seq_pkg::seq_state_s q;  // Registered state
  panel_seq_pkg::seq_state_s d;  // Next state
  panel_seq_pkg::pixel_s word;   // Decoded link word
  panel_seq_pkg::pixel_s push_data;  // Word as written to FIFO
  logic cap;          // Link clock rising edge seen
  logic shut_rise;    // Shutdown request rising edge
  logic vs_fall;      // Frame sync falling edge
  logic fifo_ready;   // FIFO can take a word

  // ----------------------------------------------------------------
  // Lane decoding
  // ----------------------------------------------------------------
  // Put one lane's slots back into bit order
  function automatic logic [6:0] slots_to_bits(input logic [6:0] slots);
    logic [6:0] bits;
    bits = '0;
    for (int b = 0; b < 7; b++)
    begin
      bits[b] = slots[SLOT_OF_BIT[b]];
    end
    return bits;
  endfunction

  // Assemble the pixel word from the four lanes
  function automatic panel_seq_pkg::pixel_s decode(input logic [3:0][6:0] lanes);
    panel_seq_pkg::lane_a_s la;
    panel_seq_pkg::lane_b_s lb;
    panel_seq_pkg::lane_c_s lc;
    panel_seq_pkg::lane_d_s ld;
    panel_seq_pkg::pixel_s p;
    la = slots_to_bits(lanes[`LANE_IDX_A]);
    lb = slots_to_bits(lanes[`LANE_IDX_B]);
    lc = slots_to_bits(lanes[`LANE_IDX_C]);
    ld = slots_to_bits(lanes[`LANE_IDX_D]);
    p.line_sync_pulse = lc.line_sync_pulse;
    p.frame_sync_pulse = lc.frame_sync_pulse;
    p.pixel_valid_window = lc.pixel_valid_window;
    p.red = {la.red_hi, ld.red_lo};
    p.green = {lb.green_hi, la.green_b2, ld.green_lo};
    p.blue = {lc.blue_hi, lb.blue_mid, ld.blue_lo};
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Edge finding on synchronised inputs
  // ----------------------------------------------------------------
  assign cap = q.clk_sync[1] && !q.clk_prev;
  assign shut_rise = q.shut_sync[1] && !q.shut_prev;
  assign word = decode(q.lane_s2);
  assign vs_fall = cap && q.vs_prev && !word.frame_sync_pulse;

  // Blank colour outside the image window, keep timing flags
  always_comb
  begin
    push_data = word;
    if (!q.disp_on)
    begin
      push_data.red = `PIX_BLACK;
      push_data.green = `PIX_BLACK;
      push_data.blue = `PIX_BLACK;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // Two-stage synchronisers
    d.clk_sync = {q.clk_sync[0], link_clk_i};
    d.shut_sync = {q.shut_sync[0], shutdown_req_i};
    d.lane_s1 = lane_slots_i;
    d.lane_s2 = q.lane_s1;
    d.clk_prev = q.clk_sync[1];
    d.shut_prev = q.shut_sync[1];
    // Track frame sync per link word
    if (cap)
    begin
      d.vs_prev = word.frame_sync_pulse;
    end
    // Sticky: a word arrived while the FIFO was full
    d.overrun = q.overrun || (cap && !fifo_ready);
    unique case (q.st)
      // Blanked, counting falls until the image may start
      panel_seq_pkg::ST_WAIT:
      begin
        if (shut_rise)
        begin
          d.st = panel_seq_pkg::ST_OFFSEQ;
          d.fall_cnt = '0;
        end
        else if (vs_fall)
        begin
          if (q.fall_cnt == `PS_START_LAST)
          begin
            d.st = panel_seq_pkg::ST_ON;
            d.fall_cnt = '0;
          end
          else
          begin
            d.fall_cnt = q.fall_cnt + `PS_CNT_STEP;
          end
        end
      end
      // Image shown until shutdown rises
      panel_seq_pkg::ST_ON:
      begin
        if (shut_rise)
        begin
          d.st = panel_seq_pkg::ST_OFFSEQ;
          d.fall_cnt = '0;
        end
      end
      // First fall opens period one; fall ending period seven finishes
      panel_seq_pkg::ST_OFFSEQ:
      begin
        if (vs_fall)
        begin
          if (q.fall_cnt == `PS_OFF_PERIODS)
          begin
            d.st = panel_seq_pkg::ST_OFF;
          end
          else
          begin
            d.fall_cnt = q.fall_cnt + `PS_CNT_STEP;
          end
        end
      end
      // Held until reset
      panel_seq_pkg::ST_OFF:
      begin
        d.st = panel_seq_pkg::ST_OFF;
      end
    endcase
    // Status flags follow the next state
    d.disp_on = (d.st == panel_seq_pkg::ST_ON);
    d.off_busy = (d.st == panel_seq_pkg::ST_OFFSEQ);
    d.panel_off = (d.st == panel_seq_pkg::ST_OFF);
  end

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
      // Edge finder starts at the idle link level, so no false capture follows reset
      q.clk_sync <= {2{`LINK_CLK_IDLE}};
      q.clk_prev <= `LINK_CLK_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Pixel FIFO and outputs
  // ----------------------------------------------------------------
  pixel_fifo #(
    .WIDTH($bits(panel_seq_pkg::pixel_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(cap),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data),
    .out_valid_o(px_valid_o),
    .out_ready_i(px_ready_i),
    .out_data_o(px_data_o)
  );

  assign display_on_o = q.disp_on;
  assign power_off_busy_o = q.off_busy;
  assign panel_off_o = q.panel_off;
  assign rx_overrun_o = q.overrun;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_ninth_fall;
    (q.st == panel_seq_pkg::ST_WAIT) && !shut_rise && vs_fall
      && (q.fall_cnt == `PS_START_LAST);
  endsequence

  property p_start_ninth;
    s_ninth_fall |=> display_on_o && !power_off_busy_o;
  endproperty
  a_start_ninth: assert property (p_start_ninth) else $error("Display did not start on ninth fall");

  property p_no_early_on;
    $rose(display_on_o) |-> $past(vs_fall) && ($past(q.fall_cnt) == `PS_START_LAST);
  endproperty
  a_no_early_on: assert property (p_no_early_on) else $error("Display started off the ninth fall");

  property p_shut_from_on;
    (q.st == panel_seq_pkg::ST_ON) && shut_rise |=> power_off_busy_o && !display_on_o;
  endproperty
  a_shut_from_on: assert property (p_shut_from_on) else $error("Shutdown edge did not start off sequence");

  property p_shut_early;
    (q.st == panel_seq_pkg::ST_WAIT) && shut_rise |=> power_off_busy_o ##0 (q.fall_cnt == '0);
  endproperty
  a_shut_early: assert property (p_shut_early) else $error("Early shutdown skipped off sequence");

  sequence s_last_off_fall;
    (q.st == panel_seq_pkg::ST_OFFSEQ) && vs_fall && (q.fall_cnt == `PS_OFF_PERIODS);
  endsequence

  property p_off_done;
    s_last_off_fall |=> panel_off_o && !power_off_busy_o ##1 panel_off_o;
  endproperty
  a_off_done: assert property (p_off_done) else $error("Off sequence length wrong");

  property p_off_early;
    (q.st == panel_seq_pkg::ST_OFFSEQ) && (!vs_fall || (q.fall_cnt != `PS_OFF_PERIODS))
      |=> !panel_off_o;
  endproperty
  a_off_early: assert property (p_off_early) else $error("Off state reached too soon");

  property p_off_blank;
    panel_off_o |=> panel_off_o && !display_on_o;
  endproperty
  a_off_blank: assert property (p_off_blank) else $error("Panel left off state");

  property p_blank_data;
    cap && !q.disp_on |-> (push_data.red == `PIX_BLACK) && (push_data.blue == `PIX_BLACK)
      && (push_data.frame_sync_pulse == word.frame_sync_pulse);
  endproperty
  a_blank_data: assert property (p_blank_data) else $error("Colour passed while blanked");

  property p_slot_order;
    cap |-> (word.red[2] == q.lane_s2[`LANE_IDX_A][1])
      && (word.red[3] == q.lane_s2[`LANE_IDX_A][0])
      && (word.pixel_valid_window == q.lane_s2[`LANE_IDX_C][2]);
  endproperty
  a_slot_order: assert property (p_slot_order) else $error("Lane slot order broken");

endmodule

`default_nettype wire

// file: tb/host_link_model.sv
/*
  Host model: serialises pixel words onto four slot-ordered lanes.
  Assumes the system clock; one link period is ten system cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module host_link_model (
  input wire logic sys_clk_i,
  input wire logic en_i,
  input wire panel_seq_pkg::pixel_s word_i,
  output var logic link_clk_o,
  output var logic [3:0][6:0] lane_slots_o,
  output var logic load_o
);
  // ----------------------------------------------------------------
  // Lane encoding
  // ----------------------------------------------------------------
  logic [2:0] ph_q; // Half-period phase count

  // Puts lane bits into slot order, slot0 first
  function automatic logic [6:0] to_slots(input logic [6:0] b);
    to_slots = {b[2], b[3], b[4], b[5], b[6], b[0], b[1]};
  endfunction

  // Maps one pixel word onto the four lanes
  function automatic logic [3:0][6:0] pack(input panel_seq_pkg::pixel_s w);
    pack[0] = to_slots({w.green[2], w.red[7:2]});
    pack[1] = to_slots({w.blue[3:2], w.green[7:3]});
    pack[2] = to_slots({w.pixel_valid_window, w.frame_sync_pulse, w.line_sync_pulse,
      w.blue[7:4]});
    pack[3] = to_slots({^w, w.blue[1:0], w.green[1:0], w.red[1:0]});
  endfunction

  // ----------------------------------------------------------------
  // Link clock and data launch
  // ----------------------------------------------------------------
  initial
  begin
    link_clk_o = 1'h1;
    lane_slots_o = '0;
    load_o = 1'h0;
    ph_q = 3'h0;
  end

  // Clock runs while enabled and stops high; lanes change at the fall
  always @(posedge sys_clk_i)
  begin
    load_o <= 1'h0;
    if (link_clk_o && !en_i)
    begin
      // Idle: no signals before the host starts; lanes carry noise
      ph_q <= 3'h0;
      lane_slots_o <= ~lane_slots_o;
    end
    else
    begin
      ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
      if (ph_q == 3'h4)
      begin
        link_clk_o <= ~link_clk_o;
        if (link_clk_o)
        begin
          lane_slots_o <= pack(word_i);
          load_o <= 1'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/tb_top.sv
/*
  Self-checking bench for the panel sequencer: frames, shutdown, overrun.
  Assumes host_link_model as the far side and the design's package.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int DEPTH = 32; // FIFO depth handed to the design
  logic clk = 1'h0, resetn = 1'h0, shut = 1'h0, px_ready = 1'h0, en = 1'h0;
  logic link_clk, load, px_valid, disp_on, off_busy, panel_off, overrun;
  logic mon_off = 1'h0; // Count words instead of comparing
  logic [3:0][6:0] lanes;
  panel_seq_pkg::pixel_s word = '0, px_data;
  panel_seq_pkg::pixel_s exp_q[$]; // Expected words in arrival order
  int err_count = 0, checks_done = 0, seed = 32'hc09c;
  int st = 0, falls = 0, offc = 0, ready_mode = 0, drained = 0;

  panel_power_sequence_lvds_rx #(.FIFO_DEPTH(DEPTH)) panel_power_sequence_lvds_rx_inst (
    .sys_clk_i(clk), .resetn_i(resetn), .link_clk_i(link_clk), .lane_slots_i(lanes),
    .shutdown_req_i(shut), .px_ready_i(px_ready), .px_valid_o(px_valid),
    .px_data_o(px_data), .display_on_o(disp_on), .power_off_busy_o(off_busy),
    .panel_off_o(panel_off), .rx_overrun_o(overrun));

  host_link_model host_link_model_inst (
    .sys_clk_i(clk), .en_i(en), .word_i(word), .link_clk_o(link_clk),
    .lane_slots_o(lanes), .load_o(load));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Resets design and bench model; shutdown stays low through power-on
  task automatic do_reset;
    resetn <= 1'h0;
    shut <= 1'h0;
    en <= 1'h0;
    repeat (8) @(posedge clk);
    exp_q.delete();
    st = 0;
    falls = 0;
    resetn <= 1'h1;
    @(posedge clk);
  endtask

  // Hands one word to the host model and notes what must come out
  task automatic send(input logic hs, input logic vs, input logic de);
    panel_seq_pkg::pixel_s w;
    panel_seq_pkg::pixel_s e;
    int k;
    w = {hs, vs, de, 24'h00_0000};
    if (de)
      w[23:0] = 24'($random(seed));
    e = w;
    if (st != 1)
      e[23:0] = 24'h00_0000;
    word <= w;
    en <= 1'h1;
    if (!mon_off)
      exp_q.push_back(e);
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (load !== 1'h1 && k < 40);
    if (k >= 40)
    begin
      err_count++;
      $display("wrong value link load expected 1 seen 0");
      wrap_up();
    end
  endtask

  // One frame: sync word, falling sync word, two pixel words
  task automatic frame(input bit req);
    send(1'h1, 1'h1, 1'h0);
    if (req && st < 2)
    begin
      shut <= 1'h1;
      st = 2;
      offc = 0;
    end
    send(1'h0, 1'h0, 1'h0);
    falls++;
    if (st == 0 && falls == 9)
      st = 1;
    else if (st == 2)
    begin
      offc++;
      if (offc == 8)
        st = 3;
    end
    send(1'h0, 1'h0, 1'h1);
    send(1'h0, 1'h0, 1'h1);
    check("display_on", st == 1, disp_on);
    check("off_busy", st == 2, off_busy);
    check("panel_off", st == 3, panel_off);
  endtask

  // Stops the link, drains the FIFO and checks nothing is left
  task automatic finish_phase(input string name);
    en <= 1'h0;
    ready_mode = 1;
    repeat (40) @(posedge clk);
    check("words left", 0, exp_q.size());
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // Downstream side
  // ----------------------------------------------------------------
  // Ready: random stalls, always on, or held off
  always @(posedge clk)
  begin
    px_ready <= (ready_mode == 1) ? 1'h1 : (ready_mode == 2) ? 1'h0 : 1'($random(seed));
  end

  // Compares each taken word with the oldest note; while mon_off it counts the word instead
  always @(posedge clk)
  begin
    if (resetn === 1'h1 && px_valid === 1'h1 && px_ready === 1'h1)
    begin
      if (mon_off)
        drained++;
      else if (exp_q.size() == 0)
      begin
        err_count++;
        $display("wrong value pixel expected none seen %h", px_data);
      end
      else
        check("pixel", exp_q.pop_front(), px_data);
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    check("px_valid", 0, px_valid);
    check("display_on", 0, disp_on);
    check("overrun", 0, overrun);
    repeat (12) frame(1'h0);
    frame(1'h1);
    repeat (8) frame(1'h0);
    finish_phase("power_on_off");
    do_reset();
    ready_mode = 0;
    repeat (3) frame(1'h0);
    frame(1'h1);
    repeat (8) frame(1'h0);
    finish_phase("early_shutdown");
    // Fill past the FIFO with the far side stalled
    mon_off = 1'h1;
    ready_mode = 2;
    repeat (DEPTH + 8) send(1'h0, 1'h0, 1'h1);
    en <= 1'h0;
    repeat (20) @(posedge clk);
    check("overrun", 1, overrun);
    drained = 0;
    ready_mode = 1;
    repeat (80) @(posedge clk);
    check("drained in range", 1, drained >= DEPTH && drained <= DEPTH + 1);
    $display("test overrun done");
    wrap_up();
  end

  // Cuts a hang short
  initial
  begin
    #200000;
    err_count++;
    $display("wrong value run time expected finish seen timeout");
    wrap_up();
  end
endmodule

`default_nettype wire
